//--- design/pdc_bank.sv
// Purpose: One post-divider bank: divisor output plus fixed /2, /3, /4 taps
// Assumes: Input clock is given as a one-cycle rising-edge strobe on the system clock
// Notes: All taps advance on the same input edge so their rises can line up
`timescale 1ns/10ps
module pdc_bank (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic edge_i,
    input wire logic [6:0] divisor_i,
    output pdc_pkg::pdc_bank_out_t out_o
);
    logic [6:0] div_cnt_reg;
    logic [1:0] third_cnt_reg;
    logic [1:0] quarter_cnt_reg;
    logic half_reg;
    logic div_out_reg;
    logic [6:0] half_point;

    assign half_point = {1'b0, divisor_i[6:1]};

    ////////////////////////////////////////////////////////////////////////
    // Divisor count restarts at zero with a rising output, so when the divisor
    // is a multiple of the tap ratio each tap rises on the same edge
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_cnt_reg <= 7'h00;
        end else if (edge_i) begin
            if (div_cnt_reg >= divisor_i - 7'h01) begin
                div_cnt_reg <= 7'h00;
            end else begin
                div_cnt_reg <= div_cnt_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_out_reg <= 1'b0;
            half_reg <= 1'b0;
            third_cnt_reg <= 2'h0;
            quarter_cnt_reg <= 2'h0;
        end else if (edge_i) begin
            div_out_reg <= (div_cnt_reg >= divisor_i - 7'h01) ||
                (div_cnt_reg + 7'h01 < half_point);
            // Fixed taps resync to the divisor wrap to keep rise alignment
            if (div_cnt_reg >= divisor_i - 7'h01) begin
                half_reg <= 1'b1;
                third_cnt_reg <= 2'h0;
                quarter_cnt_reg <= 2'h0;
            end else begin
                half_reg <= ~half_reg;
                third_cnt_reg <= (third_cnt_reg == 2'h2) ? 2'h0 : third_cnt_reg + 2'h1;
                quarter_cnt_reg <= quarter_cnt_reg + 2'h1;
            end
        end
    end

    assign out_o.clk_divisor = div_out_reg;
    assign out_o.clk_half = half_reg;
    assign out_o.clk_third = (third_cnt_reg == 2'h0);
    assign out_o.clk_quarter = ~quarter_cnt_reg[1];
endmodule

//--- design/pdc_top.sv
// Purpose: Register file, source muxes, divider banks and output crosspoint
// Assumes: The I2C engine outside delivers address and data bytes as strobes
// Notes: Reference and VCO pins are sampled, so output rates are below CLK_SYS_I/2
`timescale 1ns/10ps
module pdc_top (
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    input wire logic START_I,
    input wire logic ADDR_STB_I,
    input wire logic DATA_STB_I,
    input wire logic [7:0] WDATA_I,
    input wire logic [7:0] RADDR_I,
    output logic [7:0] RDATA_O,
    input wire logic REF_CLK_I,
    input wire logic VCO_CLK_I,
    output logic [5:0] CLK_OUT_O,
    output logic [11:0] MULT_TOTAL_O,
    output logic [7:0] PREDIV_TOTAL_O,
    output logic [2:0] PUMP_CODE_O,
    output logic [7:0] LOAD_TRIM_O
);
    logic [7:0] addr_reg;
    logic [5:0] oe_reg;
    pdc_pkg::pdc_bank_cfg_t bank1_reg;
    pdc_pkg::pdc_bank_cfg_t bank2_reg;
    logic [7:0] trim_reg;
    logic [4:0] pump_hi_reg;
    logic [7:0] mult_lo_reg;
    logic [7:0] odd_prediv_reg;
    logic [7:0] xpt_a_reg;
    logic [7:0] xpt_b_reg;
    logic [1:0] xpt_c_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [1:0] ref_sync_reg;
    logic [1:0] vco_sync_reg;
    logic ref_prev_reg;
    logic vco_prev_reg;
    logic ref_edge;
    logic vco_edge;
    logic bank1_edge;
    logic bank2_edge;
    pdc_pkg::pdc_bank_out_t bank1_out;
    pdc_pkg::pdc_bank_out_t bank2_out;
    logic [17:0] src_codes;
    logic [5:0] clk_out_reg;
    logic [5:0] clk_out_next;
    logic [9:0] base_mult;

    ////////////////////////////////////////////////////////////////////////
    // Address pointer: set by the address byte, advanced after each data byte
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            addr_reg <= 8'h00;
        end else if (ADDR_STB_I) begin
            addr_reg <= WDATA_I;
        end else if (DATA_STB_I && !START_I) begin
            // An ignored data byte must not move the pointer either
            addr_reg <= addr_reg + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes; reserved addresses are simply not stored here
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            oe_reg <= 6'h00;
            bank1_reg <= pdc_pkg::RST_BANK_REG;
            bank2_reg <= pdc_pkg::RST_BANK_REG;
            trim_reg <= pdc_pkg::RST_ZERO;
            pump_hi_reg <= 5'h00;
            mult_lo_reg <= pdc_pkg::RST_ZERO;
            odd_prediv_reg <= pdc_pkg::RST_ZERO;
            xpt_a_reg <= pdc_pkg::RST_ZERO;
            xpt_b_reg <= pdc_pkg::RST_ZERO;
            xpt_c_reg <= 2'h0;
        end else if (DATA_STB_I && !START_I) begin
            unique case (addr_reg)
                pdc_pkg::OFS_OUT_ENABLE: begin
                    oe_reg <= WDATA_I[5:0];
                end
                pdc_pkg::OFS_BANK1: begin
                    bank1_reg <= WDATA_I;
                end
                pdc_pkg::OFS_LOAD_TRIM: begin
                    trim_reg <= WDATA_I;
                end
                pdc_pkg::OFS_PUMP_MULT_HI: begin
                    pump_hi_reg <= WDATA_I[4:0];
                end
                pdc_pkg::OFS_MULT_LO: begin
                    mult_lo_reg <= WDATA_I;
                end
                pdc_pkg::OFS_ODD_PREDIV: begin
                    odd_prediv_reg <= WDATA_I;
                end
                pdc_pkg::OFS_XPT_A: begin
                    xpt_a_reg <= WDATA_I;
                end
                pdc_pkg::OFS_XPT_B: begin
                    xpt_b_reg <= WDATA_I;
                end
                pdc_pkg::OFS_XPT_C: begin
                    // Low six bits are fixed ones; only the two codes bits store
                    xpt_c_reg <= WDATA_I[7:6];
                end
                pdc_pkg::OFS_BANK2: begin
                    bank2_reg <= WDATA_I;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-back mirrors stored fields; fixed bits read as their fixed values
    always_comb begin
        rdata_next = 8'h00;
        unique case (RADDR_I)
            pdc_pkg::OFS_OUT_ENABLE: rdata_next = {2'h0, oe_reg};
            pdc_pkg::OFS_BANK1: rdata_next = bank1_reg;
            pdc_pkg::OFS_LOAD_TRIM: rdata_next = trim_reg;
            pdc_pkg::OFS_PUMP_MULT_HI: rdata_next = {pdc_pkg::PUMP_FIXED_TOP, pump_hi_reg};
            pdc_pkg::OFS_MULT_LO: rdata_next = mult_lo_reg;
            pdc_pkg::OFS_ODD_PREDIV: rdata_next = odd_prediv_reg;
            pdc_pkg::OFS_XPT_A: rdata_next = xpt_a_reg;
            pdc_pkg::OFS_XPT_B: rdata_next = xpt_b_reg;
            pdc_pkg::OFS_XPT_C: rdata_next = {xpt_c_reg, pdc_pkg::XPT_C_FILL};
            pdc_pkg::OFS_BANK2: rdata_next = bank2_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign RDATA_O = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // PLL setting outputs toward the analog loop
    assign base_mult = {pump_hi_reg[1:0], mult_lo_reg};
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            MULT_TOTAL_O <= 12'h008;
            PREDIV_TOTAL_O <= 8'h02;
            PUMP_CODE_O <= 3'h0;
            LOAD_TRIM_O <= 8'h00;
        end else begin
            // Range 8..2055 falls out of the 10-bit field and 11-bit sum
            // The 11-bit sum shifted left one place, with the odd bit in the LSB, needs all twelve bits
            MULT_TOTAL_O <= {({1'b0, base_mult} + pdc_pkg::MULT_BASE_OFFSET),
                odd_prediv_reg[7]};
            PREDIV_TOTAL_O <= {1'b0, odd_prediv_reg[6:0]} + pdc_pkg::PREDIV_OFFSET;
            PUMP_CODE_O <= pump_hi_reg[4:2];
            LOAD_TRIM_O <= trim_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling; first stage feeds only the second
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ref_sync_reg <= 2'h0;
            vco_sync_reg <= 2'h0;
            ref_prev_reg <= 1'b0;
            vco_prev_reg <= 1'b0;
        end else begin
            ref_sync_reg <= {ref_sync_reg[0], REF_CLK_I};
            vco_sync_reg <= {vco_sync_reg[0], VCO_CLK_I};
            ref_prev_reg <= ref_sync_reg[1];
            vco_prev_reg <= vco_sync_reg[1];
        end
    end

    assign ref_edge = ref_sync_reg[1] & ~ref_prev_reg;
    assign vco_edge = vco_sync_reg[1] & ~vco_prev_reg;
    assign bank1_edge = bank1_reg.select_ref ? vco_edge : ref_edge;
    assign bank2_edge = bank2_reg.select_ref ? vco_edge : ref_edge;

    pdc_bank u_bank1 (
        .clk_i(CLK_SYS_I),
        .arst_n_i(ARST_N_I),
        .edge_i(bank1_edge),
        .divisor_i(bank1_reg.divisor),
        .out_o(bank1_out)
    );

    pdc_bank u_bank2 (
        .clk_i(CLK_SYS_I),
        .arst_n_i(ARST_N_I),
        .edge_i(bank2_edge),
        .divisor_i(bank2_reg.divisor),
        .out_o(bank2_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Crosspoint: codes MSB first, output 0 in the top bits
    assign src_codes = {xpt_a_reg, xpt_b_reg, xpt_c_reg};

    function automatic logic pick_source(input logic [2:0] code,
                                         input logic ref_lvl,
                                         input pdc_pkg::pdc_bank_out_t b1,
                                         input pdc_pkg::pdc_bank_out_t b2);
        logic res;
        res = 1'b0;
        unique case (pdc_pkg::pdc_src_t'(code))
            pdc_pkg::SRC_REFERENCE: res = ref_lvl;
            pdc_pkg::SRC_BANK1_DIVISOR: res = b1.clk_divisor;
            pdc_pkg::SRC_BANK1_HALF: res = b1.clk_half;
            pdc_pkg::SRC_BANK1_THIRD: res = b1.clk_third;
            pdc_pkg::SRC_BANK2_DIVISOR: res = b2.clk_divisor;
            pdc_pkg::SRC_BANK2_HALF: res = b2.clk_half;
            pdc_pkg::SRC_BANK2_QUARTER: res = b2.clk_quarter;
            pdc_pkg::SRC_RESERVED: res = 1'b0;
        endcase
        return res;
    endfunction

    genvar g;
    generate
        for (g = 0; g < pdc_pkg::NUM_OUTPUTS; g++) begin : g_out
            // Disabled outputs park low rather than float, which keeps loads quiet
            assign clk_out_next[g] = oe_reg[g] &
                pick_source(src_codes[17 - 3 * g -: 3], ref_sync_reg[1],
                            bank1_out, bank2_out);
        end
    endgenerate

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            clk_out_reg <= 6'h00;
        end else begin
            clk_out_reg <= clk_out_next;
        end
    end

    assign CLK_OUT_O = clk_out_reg;
endmodule

//--- inc/pdc_pkg.sv
// Purpose: Shared constants and types for the PLL divider and crosspoint configuration block
// Assumes: One system clock; the VCO and reference arrive as sampled pins
// Notes: Register offsets are the byte addresses of an 8-bit register space
// What this block does
// - Multiplier total is 2*(base+4)+odd bit
// - Base multiplier: 0x40[1:0] high, 0x41 low
// - Pump code 0x40[4:2]; top bits fixed 110
// - Odd bit 0x42[7]; predivider 0x42[6:0]
// - Multiplier total spans 8 to 2055
// - Each bank muxes VCO or reference input
// - 0x0C and 0x47: select bit7, divisor 6:0
// - Each output picks one of seven sources
// - Source code decode table, 111 reserved
// - Bank1 /2,/3 rise-aligned with divisor output
// - Bank2 /2,/4 rise-aligned with divisor output
// - Source codes packed MSB first 0x44..0x46
// - Per-output enable bits in 0x09[5:0]
// - Predivider total is field plus 2
// - Enable bit map; 0x09[7:6] read zero
// - Write address then data, auto-incrementing
package pdc_pkg;
    localparam logic [7:0] OFS_OUT_ENABLE = 8'h09;
    localparam logic [7:0] OFS_BANK1 = 8'h0C;
    localparam logic [7:0] OFS_LOAD_TRIM = 8'h13;
    localparam logic [7:0] OFS_PUMP_MULT_HI = 8'h40;
    localparam logic [7:0] OFS_MULT_LO = 8'h41;
    localparam logic [7:0] OFS_ODD_PREDIV = 8'h42;
    localparam logic [7:0] OFS_XPT_A = 8'h44;
    localparam logic [7:0] OFS_XPT_B = 8'h45;
    localparam logic [7:0] OFS_XPT_C = 8'h46;
    localparam logic [7:0] OFS_BANK2 = 8'h47;
    localparam logic [2:0] PUMP_FIXED_TOP = 3'h6;
    localparam logic [5:0] XPT_C_FILL = 6'h3F;
    localparam logic [6:0] RST_BANK_DIVISOR = 7'h08;
    localparam logic [7:0] RST_BANK_REG = 8'h08;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [10:0] MULT_BASE_OFFSET = 11'h004;
    localparam logic [7:0] PREDIV_OFFSET = 8'h02;
    localparam int NUM_OUTPUTS = 6;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        SRC_REFERENCE = 3'h0,
        SRC_BANK1_DIVISOR = 3'h1,
        SRC_BANK1_HALF = 3'h2,
        SRC_BANK1_THIRD = 3'h3,
        SRC_BANK2_DIVISOR = 3'h4,
        SRC_BANK2_HALF = 3'h5,
        SRC_BANK2_QUARTER = 3'h6,
        SRC_RESERVED = 3'h7
    } pdc_src_t;

    typedef struct packed {
        logic select_ref;
        logic [6:0] divisor;
    } pdc_bank_cfg_t;

    typedef struct packed {
        logic clk_divisor;
        logic clk_half;
        logic clk_third;
        logic clk_quarter;
    } pdc_bank_out_t;
endpackage

//--- tb/pdc_host_model.sv
// Purpose: Register-writing host seen through the byte strobes of the serial engine
// Assumes: A frame is start byte, register address, then data bytes
// Notes: Idle data bus shows the inverse of the last byte, never a stale copy
`timescale 1ns/10ps
module pdc_host_model (
    input wire logic clk_i,
    output logic start_o,
    output logic addr_stb_o,
    output logic data_stb_o,
    output logic [7:0] wdata_o
);
    initial begin
        start_o = 1'b0;
        addr_stb_o = 1'b0;
        data_stb_o = 1'b0;
        wdata_o = 8'h00;
    end
    // Callers pick legal divisor, pump and multiplier values, no reserved address
    task automatic frame(input logic [7:0] addr, input logic [23:0] bytes, input int n);
        logic [7:0] ma;
        logic [7:0] b;
        ma = addr;
        @(posedge clk_i);
        start_o <= 1'b1;
        wdata_o <= 8'hD2;
        @(posedge clk_i);
        start_o <= 1'b0;
        addr_stb_o <= 1'b1;
        wdata_o <= ma;
        for (int i = n - 1; i >= 0; i--) begin
            b = bytes[8*i +: 8];
            if (ma == pdc_pkg::OFS_XPT_C) begin
                b[5:0] = pdc_pkg::XPT_C_FILL;
            end
            @(posedge clk_i);
            addr_stb_o <= 1'b0;
            data_stb_o <= 1'b1;
            wdata_o <= b;
            ma = ma + 8'h01;
        end
        @(posedge clk_i);
        data_stb_o <= 1'b0;
        wdata_o <= ~b;
    endtask
endmodule

//--- tb/pdc_top_monitor.sv
// Purpose: Port checker for the clock configuration block
// Assumes: A shadow of the written registers is rebuilt from the byte strobes
// Notes: Value checks wait until no write has been seen for seven cycles
`timescale 1ns/10ps
module pdc_top_monitor (
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    input wire logic START_I,
    input wire logic ADDR_STB_I,
    input wire logic DATA_STB_I,
    input wire logic [7:0] WDATA_I,
    input wire logic [7:0] RADDR_I,
    input wire logic [7:0] RDATA_O,
    input wire logic [5:0] CLK_OUT_O,
    input wire logic [11:0] MULT_TOTAL_O,
    input wire logic [7:0] PREDIV_TOTAL_O,
    input wire logic [2:0] PUMP_CODE_O
);
    logic [7:0] ptr_reg;
    logic [2:0] quiet_reg;
    logic [7:0] sh_reg [0:127];
    logic [17:0] codes;
    logic [11:0] mult_exp;
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ptr_reg <= 8'h00;
            quiet_reg <= 3'h0;
            for (int i = 0; i < 128; i++) begin
                sh_reg[i] <= 8'h00;
            end
        end else if (ADDR_STB_I) begin
            ptr_reg <= WDATA_I;
            quiet_reg <= 3'h0;
        end else if (DATA_STB_I && !START_I) begin
            // Upper half of the map is all reserved, so it needs no shadow
            if (!ptr_reg[7]) begin
                sh_reg[ptr_reg[6:0]] <= WDATA_I;
            end
            ptr_reg <= ptr_reg + 8'h01;
            quiet_reg <= 3'h0;
        end else if (quiet_reg != 3'h7) begin
            quiet_reg <= quiet_reg + 3'h1;
        end
    end
    assign codes = {sh_reg[7'h44], sh_reg[7'h45], sh_reg[7'h46][7:6]};
    assign mult_exp = {1'b0, sh_reg[7'h40][1:0], sh_reg[7'h41], 1'b0} + 12'h008
        + {11'h000, sh_reg[7'h42][7]};
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!ARST_N_I);
    a_mult_total: assert property (quiet_reg == 3'h7 |-> MULT_TOTAL_O == mult_exp)
        else $error("multiplier total does not match stored fields");
    a_prediv_total: assert property (quiet_reg == 3'h7 |->
        PREDIV_TOTAL_O == {1'b0, sh_reg[7'h42][6:0]} + 8'h02)
        else $error("predivider total does not match stored field");
    a_pump_code: assert property (quiet_reg == 3'h7 |-> PUMP_CODE_O == sh_reg[7'h40][4:2])
        else $error("pump code does not match stored field");
    a_total_change: assert property ($changed(MULT_TOTAL_O) |-> $past(quiet_reg) < 3'h3)
        else $error("multiplier total moved without a write");
    a_enable_read: assert property (quiet_reg != 3'h0 && $past(RADDR_I) == 8'h09 |->
        RDATA_O[7:6] == 2'h0)
        else $error("enable register top bits not zero");
    a_pump_top_read: assert property (quiet_reg != 3'h0 && $past(RADDR_I) == 8'h40 |->
        RDATA_O[7:5] == 3'h6)
        else $error("pump register fixed bits wrong");
    a_fill_read: assert property (quiet_reg != 3'h0 && $past(RADDR_I) == 8'h46 |->
        RDATA_O[5:0] == 6'h3F)
        else $error("crosspoint fill bits wrong");
    a_out_disabled: assert property (quiet_reg == 3'h7 |->
        (CLK_OUT_O & ~sh_reg[7'h09][5:0]) == 6'h00)
        else $error("disabled output not held low");
    for (genvar g = 0; g < 6; g++) begin : g_out
        a_reserved_low: assert property (quiet_reg == 3'h7 && codes[17-3*g -: 3] == 3'h7 |->
            !CLK_OUT_O[g])
            else $error("reserved source code output toggles");
    end
    c_max_total: cover property (MULT_TOTAL_O == 12'd2055);
    c_out_rise: cover property ($rose(CLK_OUT_O[0]));
    c_reserved: cover property (codes[14:12] == 3'h7 && quiet_reg == 3'h7);
endmodule
bind pdc_top pdc_top_monitor mon_u (.CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I),
    .START_I(START_I), .ADDR_STB_I(ADDR_STB_I), .DATA_STB_I(DATA_STB_I), .WDATA_I(WDATA_I),
    .RADDR_I(RADDR_I), .RDATA_O(RDATA_O), .CLK_OUT_O(CLK_OUT_O), .MULT_TOTAL_O(MULT_TOTAL_O),
    .PREDIV_TOTAL_O(PREDIV_TOTAL_O), .PUMP_CODE_O(PUMP_CODE_O));

//--- tb/pdc_top_test.sv
// Purpose: Self-checking bench for the clock configuration block
// Assumes: Reference and VCO pins toggle slowly against the system clock
// Notes: Output rates are checked as periods counted in system cycles
`timescale 1ns/10ps
module pdc_top_test;
    localparam int RH = 4;
    localparam int VH = 3;
    logic clk_sys, arst_n, start, addr_stb, data_stb;
    logic ref_clk = 1'b0;
    logic vco_clk = 1'b0;
    logic [7:0] wdata, raddr, rdata, prediv_total, load_trim;
    logic [5:0] clk_out, prev_out;
    logic [11:0] mult_total;
    logic [2:0] pump_code;
    int ref_cnt = 0, vco_cnt = 0, fail_count = 0, total_checks = 0;
    pdc_top dut_u (.CLK_SYS_I(clk_sys), .ARST_N_I(arst_n), .START_I(start),
        .ADDR_STB_I(addr_stb), .DATA_STB_I(data_stb), .WDATA_I(wdata), .RADDR_I(raddr),
        .RDATA_O(rdata), .REF_CLK_I(ref_clk), .VCO_CLK_I(vco_clk), .CLK_OUT_O(clk_out),
        .MULT_TOTAL_O(mult_total), .PREDIV_TOTAL_O(prediv_total), .PUMP_CODE_O(pump_code),
        .LOAD_TRIM_O(load_trim));
    pdc_host_model host_u (.clk_i(clk_sys), .start_o(start), .addr_stb_o(addr_stb),
        .data_stb_o(data_stb), .wdata_o(wdata));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        prev_out <= clk_out;
        ref_cnt <= (ref_cnt == RH - 1) ? 0 : ref_cnt + 1;
        vco_cnt <= (vco_cnt == VH - 1) ? 0 : vco_cnt + 1;
        if (ref_cnt == RH - 1) ref_clk <= ~ref_clk;
        if (vco_cnt == VH - 1) vco_clk <= ~vco_clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clk_sys);
        raddr <= addr;
        @(posedge clk_sys);
        #1 chk({8'h00, rdata}, {8'h00, exp});
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    // A limit on the wait keeps a stuck output from hanging the run
    task automatic rise(input int b, output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (!(clk_out[b] === 1'b1 && prev_out[b] === 1'b0) && n < 400);
        if (n >= 400) fail_count++;
    endtask
    task automatic per(input int b, input int exp);
        int n;
        rise(b, n);
        rise(b, n);
        rise(b, n);
        chk(16'(n), 16'(exp));
    endtask
    task automatic align(input int a, input int b);
        int n;
        rise(a, n);
        chk({15'h0, clk_out[b] & ~prev_out[b]}, 16'h1);
    endtask
    task automatic low(input int b);
        logic seen;
        seen = 1'b0;
        repeat (100) begin
            @(posedge clk_sys);
            #1 seen = seen | clk_out[b];
        end
        chk({15'h0, seen}, 16'h0);
    endtask
    function automatic logic [23:0] pk(input logic [2:0] c1, c2, c3, c4, c5, c6);
        return {c1, c2, c3, c4, c5, c6, 6'h3F};
    endfunction
    task automatic end_sim;
        $display("Checks %0d, errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk_sys);
        fail_count++;
        end_sim;
    end
    initial begin
        arst_n = 1'b0;
        raddr = 8'h00;
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        #1 chk({4'h0, mult_total}, 16'd8);
        chk({8'h0, prediv_total}, 16'd2);
        rd(8'h0C, 8'h08);
        rd(8'h47, 8'h08);
        host_u.frame(8'h40, 24'hF3FFFF, 3);
        settle;
        chk({4'h0, mult_total}, 16'd2055);
        chk({8'h0, prediv_total}, 16'd129);
        rd(8'h40, 8'hD3);
        rd(8'h42, 8'hFF);
        host_u.frame(8'h40, 24'h000000, 3);
        settle;
        chk({4'h0, mult_total}, 16'd8);
        chk({8'h0, prediv_total}, 16'd2);
        // Pump codes 0 to 4 are each paired with a total from their own band
        for (int k = 0; k < 5; k++) begin
            logic [9:0] pb;
            pb = (k == 0) ? 10'd10 : 10'(k * 100 + 50);
            host_u.frame(8'h40, {11'h0, 3'(k), pb}, 2);
            settle;
            chk({13'h0, pump_code}, 16'(k));
            chk({4'h0, mult_total}, 16'(2 * (pb + 10'd4)));
        end
        host_u.frame(8'h13, 24'h5A, 1);
        settle;
        chk({8'h0, load_trim}, 16'h005A);
        rd(8'h13, 8'h5A);
        host_u.frame(8'h45, 24'hAAC005, 3);
        rd(8'h45, 8'hAA);
        rd(8'h47, 8'h05);
        host_u.frame(8'h09, 24'h3F, 1);
        host_u.frame(8'h0C, 24'h84, 1);
        host_u.frame(8'h47, 24'h08, 1);
        host_u.frame(8'h44, pk(1, 2, 0, 4, 5, 6), 3);
        rd(8'h09, 8'h3F);
        rd(8'h46, 8'hBF);
        per(0, 8 * VH);
        per(1, 4 * VH);
        per(3, 16 * RH);
        per(4, 4 * RH);
        per(5, 8 * RH);
        align(0, 1);
        align(3, 4);
        align(3, 5);
        host_u.frame(8'h44, pk(1, 0, 0, 4, 5, 6), 3);
        host_u.frame(8'h0C, 24'h86, 1);
        host_u.frame(8'h44, pk(1, 0, 3, 4, 5, 6), 3);
        per(0, 12 * VH);
        per(2, 6 * VH);
        align(0, 2);
        host_u.frame(8'h44, pk(0, 7, 3, 4, 5, 6), 3);
        per(0, 2 * RH);
        low(1);
        host_u.frame(8'h09, 24'h3B, 1);
        low(2);
        host_u.frame(8'h09, 24'h3F, 1);
        per(2, 6 * VH);
        end_sim;
    end
endmodule
